// *** core/gssr_pkg.sv ***
// Package: constants and helpers for the status byte and service request block
package gssr_pkg;

   localparam int        BIT_OPER     = 7;
   localparam int        BIT_RQS      = 6;
   localparam int        BIT_ESB      = 5;
   localparam int        BIT_MAV      = 4;
   localparam logic [7:0] MASK_RST    = 8'h00;
   localparam logic [7:0] STB_RST     = 8'h00;
   localparam logic [7:0] SUM_IGNORE  = 8'hbf;
   localparam logic [7:0] OQ_EMPTY    = 8'h00;

   typedef enum logic [1:0] {
      ADR_IDLE,
      ADR_LISTEN,
      ADR_TALK
   } gssr_adr_e;

   function automatic logic [7:0] stb_pack(
      input logic oper,
      input logic rqs,
      input logic esb,
      input logic mav
   );
      logic [7:0] b;
      b           = 8'h00;
      b[BIT_OPER] = oper;
      b[BIT_RQS]  = rqs;
      b[BIT_ESB]  = esb;
      b[BIT_MAV]  = mav;
      return b;
   endfunction

endpackage

// *** core/gssr_stb_if.sv ***
// Interface: carries status sources and summary between top and status combiner
`timescale 1ns/1ps
interface gssr_stb_if;
   logic [7:0] oq_count;
   logic [7:0] esr_bits;
   logic [7:0] ese_bits;
   logic       oper;
   logic       rqs;
   logic [7:0] mask;
   logic       mav;
   logic       esb;
   logic [7:0] live;
   logic       sum;

   modport calc (
      input  oq_count, esr_bits, ese_bits, oper, rqs, mask,
      output mav, esb, live, sum
   );

   modport user (
      output oq_count, esr_bits, ese_bits, oper, rqs, mask,
      input  mav, esb, live, sum
   );
endinterface

// *** core/gssr_stb.sv ***
// Module: combines status sources into the live status byte and its summary
`timescale 1ns/1ps
module gssr_stb (
   gssr_stb_if.calc st
);

   logic [7:0] enabled;

   always_comb begin
      st.mav = (st.oq_count != gssr_pkg::OQ_EMPTY);
      st.esb = |(st.esr_bits & st.ese_bits);
   end

   // Masked bits stay visible in the byte
   always_comb begin
      st.live = gssr_pkg::stb_pack(st.oper, st.rqs, st.esb, st.mav);
   end

   // Bit 6 of the mask is dropped so the summary cannot feed itself
   always_comb begin
      enabled = st.live & st.mask & gssr_pkg::SUM_IGNORE;
      st.sum  = |enabled;
   end

endmodule

// *** core/gssr_top.sv ***
// Module: device-side status byte, service request and serial poll logic
`timescale 1ns/1ps
module gssr_top (
   input  wire logic       MCLK,
   input  wire logic       RST,
   input  wire logic       IFC_IN,
   input  wire logic       SPE_CMD,
   input  wire logic       SPD_CMD,
   input  wire logic       TALK_ADDR_CMD,
   input  wire logic       UNTALK_CMD,
   input  wire logic       LISTEN_ADDR_CMD,
   input  wire logic       UNLISTEN_CMD,
   input  wire logic       BYTE_TAKEN,
   input  wire logic [7:0] OQ_COUNT,
   input  wire logic [7:0] ESR_BITS,
   input  wire logic [7:0] ESE_BITS,
   input  wire logic       OPER_SUM,
   input  wire logic       MASK_WR,
   input  wire logic [7:0] MASK_WDATA,
   input  wire logic       CLS_CMD,
   input  wire logic       STB_QUERY,
   output logic            SRQ_O,
   output logic            SRQ_OE,
   output logic [7:0]      DIO_O,
   output logic            DIO_OE,
   output logic            TALK_ACT,
   output logic            LISTEN_ACT,
   output logic            POLL_ACT,
   output logic            SRQ_LAMP,
   output logic [7:0]      MASK_Q,
   output logic [7:0]      STB_RESP,
   output logic            STB_RESP_VLD
);

   gssr_stb_if           st ();

   gssr_pkg::gssr_adr_e  adr_ff;
   gssr_pkg::gssr_adr_e  nxt_adr;
   logic                 poll_ff;
   logic                 nxt_poll;
   logic [7:0]           mask_ff;
   logic [7:0]           nxt_mask;
   logic [7:0]           en_now;
   logic [7:0]           en_prev_ff;
   logic                 evt;
   logic                 clr_req;
   logic [7:0]           frozen_ff;
   logic [7:0]           nxt_frozen;
   logic                 rqs_ff;
   logic                 nxt_rqs;
   logic                 pend_ff;
   logic                 nxt_pend;
   logic                 blocked;
   logic                 promote;
   logic                 poll_read;
   logic [7:0]           dio_ff;
   logic                 dio_oe_ff;
   logic                 nxt_dio_oe;
   logic                 srq_oe_ff;
   logic                 srq_o_ff;
   logic                 lamp_ff;
   logic [7:0]           resp_ff;
   logic [7:0]           nxt_resp;
   logic                 resp_vld_ff;
   logic                 talk_ff;
   logic                 listen_ff;

   assign st.oq_count = OQ_COUNT;
   assign st.esr_bits = ESR_BITS;
   assign st.ese_bits = ESE_BITS;
   assign st.oper     = OPER_SUM;
   assign st.rqs      = rqs_ff;
   assign st.mask     = mask_ff;

   gssr_stb u_stb (
      .st (st.calc)
   );

   // Addressing. There is no controller state here: the device can only be
   // addressed, so a pass-control message has nowhere to land.
   always_comb begin
      nxt_adr = adr_ff;
      case (adr_ff)
         gssr_pkg::ADR_IDLE: begin
            if (TALK_ADDR_CMD) begin
               nxt_adr = gssr_pkg::ADR_TALK;
            end else if (LISTEN_ADDR_CMD) begin
               nxt_adr = gssr_pkg::ADR_LISTEN;
            end
         end
         gssr_pkg::ADR_LISTEN: begin
            if (TALK_ADDR_CMD) begin
               nxt_adr = gssr_pkg::ADR_TALK;
            end else if (UNLISTEN_CMD) begin
               nxt_adr = gssr_pkg::ADR_IDLE;
            end
         end
         gssr_pkg::ADR_TALK: begin
            if (LISTEN_ADDR_CMD) begin
               nxt_adr = gssr_pkg::ADR_LISTEN;
            end else if (UNTALK_CMD) begin
               nxt_adr = gssr_pkg::ADR_IDLE;
            end
         end
         default: begin
            nxt_adr = gssr_pkg::ADR_IDLE;
         end
      endcase
      // Interface clear overrides any address command in the same cycle
      if (IFC_IN) begin
         nxt_adr = gssr_pkg::ADR_IDLE;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         adr_ff <= gssr_pkg::ADR_IDLE;
      end else begin
         adr_ff <= nxt_adr;
      end
   end

   // Flags follow the next state so they never lag the address machine
   always_ff @(posedge MCLK) begin
      if (RST) begin
         talk_ff <= 1'b0;
      end else begin
         talk_ff <= (nxt_adr == gssr_pkg::ADR_TALK);
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         listen_ff <= 1'b0;
      end else begin
         listen_ff <= (nxt_adr == gssr_pkg::ADR_LISTEN);
      end
   end

   // Serial poll mode, entered by poll enable and left by disable or clear
   always_comb begin
      nxt_poll = poll_ff;
      if (SPE_CMD) begin
         nxt_poll = 1'b1;
      end
      if (SPD_CMD || IFC_IN) begin
         nxt_poll = 1'b0;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         poll_ff <= 1'b0;
      end else begin
         poll_ff <= nxt_poll;
      end
   end

   // Enable mask; new value is used by the summary on the next cycle
   always_comb begin
      nxt_mask = mask_ff;
      if (MASK_WR) begin
         nxt_mask = MASK_WDATA;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         mask_ff <= gssr_pkg::MASK_RST;
      end else begin
         mask_ff <= nxt_mask;
      end
   end

   // Rise of any single enabled bit is a new reason, so a second condition
   // arriving while another is set still counts; so does an exposing mask write
   assign en_now = st.live & mask_ff & gssr_pkg::SUM_IGNORE;

   always_ff @(posedge MCLK) begin
      if (RST) begin
         en_prev_ff <= gssr_pkg::STB_RST;
      end else begin
         en_prev_ff <= en_now;
      end
   end

   assign evt = |(en_now & ~en_prev_ff);

   // Read of the frozen byte by the controller during a poll
   assign poll_read = BYTE_TAKEN & poll_ff & talk_ff;

   // New reasons are parked while a request stands or a poll runs
   assign blocked = poll_ff | rqs_ff;
   assign promote = pend_ff & ~poll_ff & ~rqs_ff;

   assign clr_req = poll_read | CLS_CMD;

   always_comb begin
      nxt_rqs = rqs_ff;
      if (clr_req) begin
         nxt_rqs = 1'b0;
      end
      // Set wins over a clear arriving in the same cycle
      if ((evt || promote) && !blocked) begin
         nxt_rqs = 1'b1;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         rqs_ff <= 1'b0;
      end else begin
         rqs_ff <= nxt_rqs;
      end
   end

   always_comb begin
      nxt_pend = pend_ff;
      if (CLS_CMD || promote) begin
         nxt_pend = 1'b0;
      end
      // A late reason survives a clear in its own cycle
      if (evt && blocked) begin
         nxt_pend = 1'b1;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         pend_ff <= 1'b0;
      end else begin
         pend_ff <= nxt_pend;
      end
   end

   // Snapshot taken once at poll enable; nothing touches it during the poll
   always_comb begin
      nxt_frozen = frozen_ff;
      if (SPE_CMD && !poll_ff) begin
         nxt_frozen = st.live;
      end else if (CLS_CMD && !poll_ff) begin
         nxt_frozen = gssr_pkg::STB_RST;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         frozen_ff <= gssr_pkg::STB_RST;
      end else begin
         frozen_ff <= nxt_frozen;
      end
   end

   // Data lines are driven only for the poll byte; parallel poll is never
   // answered, so no other path can enable them.
   always_comb begin
      nxt_dio_oe = nxt_poll && (nxt_adr == gssr_pkg::ADR_TALK);
   end

   // Released by disable, clear, untalk or a listen address alike
   always_ff @(posedge MCLK) begin
      if (RST) begin
         dio_oe_ff <= 1'b0;
      end else begin
         dio_oe_ff <= nxt_dio_oe;
      end
   end

   // Follows the snapshot, which itself holds still for the whole poll
   always_ff @(posedge MCLK) begin
      if (RST) begin
         dio_ff <= gssr_pkg::STB_RST;
      end else begin
         dio_ff <= nxt_frozen;
      end
   end

   // Open-drain request line: pulled low while the request stands
   always_ff @(posedge MCLK) begin
      if (RST) begin
         srq_oe_ff <= 1'b0;
      end else begin
         srq_oe_ff <= nxt_rqs;
      end
   end

   // Never driven high: the line is wired, so only a low level is ever shown
   always_ff @(posedge MCLK) begin
      if (RST) begin
         srq_o_ff <= 1'b0;
      end else begin
         srq_o_ff <= 1'b0;
      end
   end

   // Lamp follows the request regardless of local or remote mode
   always_ff @(posedge MCLK) begin
      if (RST) begin
         lamp_ff <= 1'b0;
      end else begin
         lamp_ff <= nxt_rqs;
      end
   end

   // Query answer: live byte with the master summary in bit 6, no side effect
   always_comb begin
      nxt_resp = resp_ff;
      if (STB_QUERY) begin
         nxt_resp = gssr_pkg::stb_pack(OPER_SUM, st.sum, st.esb, st.mav);
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         resp_ff <= gssr_pkg::STB_RST;
      end else begin
         resp_ff <= nxt_resp;
      end
   end

   // One-cycle strobe; the data stands until the next query
   always_ff @(posedge MCLK) begin
      if (RST) begin
         resp_vld_ff <= 1'b0;
      end else begin
         resp_vld_ff <= STB_QUERY;
      end
   end

   assign SRQ_O        = srq_o_ff;
   assign SRQ_OE       = srq_oe_ff;
   assign DIO_O        = dio_ff;
   assign DIO_OE       = dio_oe_ff;
   assign TALK_ACT     = talk_ff;
   assign LISTEN_ACT   = listen_ff;
   assign POLL_ACT     = poll_ff;
   assign SRQ_LAMP     = lamp_ff;
   assign MASK_Q       = mask_ff;
   assign STB_RESP     = resp_ff;
   assign STB_RESP_VLD = resp_vld_ff;

endmodule

// *** sim/gssr_top_sva.sv ***
// Checker: port properties of the status byte and service request block
`timescale 1ns/1ps
module gssr_top_sva (
   input wire logic       MCLK,
   input wire logic       RST,
   input wire logic       IFC_IN,
   input wire logic       BYTE_TAKEN,
   input wire logic       OPER_SUM,
   input wire logic       MASK_WR,
   input wire logic [7:0] MASK_WDATA,
   input wire logic       CLS_CMD,
   input wire logic       STB_QUERY,
   input wire logic       SRQ_O,
   input wire logic       SRQ_OE,
   input wire logic [7:0] DIO_O,
   input wire logic       DIO_OE,
   input wire logic       TALK_ACT,
   input wire logic       LISTEN_ACT,
   input wire logic       POLL_ACT,
   input wire logic       SRQ_LAMP,
   input wire logic [7:0] MASK_Q,
   input wire logic [7:0] STB_RESP,
   input wire logic       STB_RESP_VLD
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);
   a_srq_pull_low: assert property (SRQ_OE |-> !SRQ_O) else $error("srq drive");
   a_lamp_tracks_srq: assert property (SRQ_LAMP == SRQ_OE) else $error("lamp");
   a_ifc_stops_all: assert property (
      IFC_IN |=> !(TALK_ACT || LISTEN_ACT || POLL_ACT || DIO_OE)) else $error("ifc");
   a_poll_byte_frozen: assert property (POLL_ACT ##1 POLL_ACT |-> $stable(DIO_O))
      else $error("frozen");
   a_poll_read_clears: assert property (POLL_ACT && TALK_ACT && BYTE_TAKEN |=> !SRQ_OE)
      else $error("poll clear");
   a_cls_withdraws_srq: assert property (CLS_CMD && SRQ_OE |=> !SRQ_OE)
      else $error("cls");
   a_talk_only_polled: assert property (DIO_OE |-> POLL_ACT) else $error("talk");
   a_mask_write_next: assert property (MASK_WR |=> MASK_Q == $past(MASK_WDATA))
      else $error("mask");
   a_query_pulse_once: assert property (STB_RESP_VLD == $past(STB_QUERY))
      else $error("vld");
   a_query_fixed_bits: assert property (
      STB_QUERY |=> STB_RESP[3:0] == 4'h0 && STB_RESP[7] == $past(OPER_SUM))
      else $error("resp bits");
   cover property ($rose(SRQ_OE));
   cover property (POLL_ACT && BYTE_TAKEN);
   cover property (STB_RESP_VLD && STB_RESP[6]);
endmodule

bind gssr_top gssr_top_sva chk_u (.MCLK(MCLK), .RST(RST), .IFC_IN(IFC_IN),
   .BYTE_TAKEN(BYTE_TAKEN), .OPER_SUM(OPER_SUM), .MASK_WR(MASK_WR), .MASK_WDATA(MASK_WDATA),
   .CLS_CMD(CLS_CMD), .STB_QUERY(STB_QUERY), .SRQ_O(SRQ_O), .SRQ_OE(SRQ_OE), .DIO_O(DIO_O),
   .DIO_OE(DIO_OE), .TALK_ACT(TALK_ACT), .LISTEN_ACT(LISTEN_ACT), .POLL_ACT(POLL_ACT),
   .SRQ_LAMP(SRQ_LAMP), .MASK_Q(MASK_Q), .STB_RESP(STB_RESP), .STB_RESP_VLD(STB_RESP_VLD));

// *** sim/gssr_ctrl_model.sv ***
// Partner model: bus controller that serial polls the device
`timescale 1ns/1ps
module gssr_ctrl_model (
   input  wire logic       MCLK,
   input  wire logic [7:0] DIO_O,
   input  wire logic       DIO_OE,
   output logic            SPE_CMD,
   output logic            TALK_ADDR_CMD,
   output logic            BYTE_TAKEN,
   output logic            SPD_CMD,
   output logic            UNTALK_CMD
);
   initial {SPE_CMD, TALK_ADDR_CMD, BYTE_TAKEN, SPD_CMD, UNTALK_CMD} = 5'h00;
   // Gap stretches the controller's reaction, a slow host
   task automatic poll(input int gap, output logic [7:0] b);
      int n;
      n = 0;
      @(negedge MCLK) SPE_CMD = 1'b1;
      @(negedge MCLK) SPE_CMD = 1'b0;
      TALK_ADDR_CMD = 1'b1;
      @(negedge MCLK) TALK_ADDR_CMD = 1'b0;
      repeat (gap) @(negedge MCLK);
      while (!DIO_OE && n < 20) begin
         @(negedge MCLK) n++;
      end
      // Byte is only read while the device drives the lines
      b = DIO_OE ? DIO_O : 8'hxx;
      BYTE_TAKEN = 1'b1;
      @(negedge MCLK) BYTE_TAKEN = 1'b0;
      SPD_CMD = 1'b1;
      @(negedge MCLK) SPD_CMD = 1'b0;
      UNTALK_CMD = 1'b1;
      @(negedge MCLK) UNTALK_CMD = 1'b0;
   endtask
endmodule

// *** sim/tb_gssr_status_service_request.sv ***
// Testbench: status byte, service request and serial poll scenarios
`timescale 1ns/1ps
module tb_gssr_status_service_request;
   logic       mclk, rst, ifc, lsn, mwr, cls, qry, oper;
   logic [7:0] oq, esr, ese, mwd, b, dio, mq, resp;
   logic       spe, spd, tad, utk, btk, srq_o, srq_oe, dio_oe, tlk, lsa, pol, lamp, vld;
   int         mismatches = 0;
   int         cmp_count = 0;

   gssr_top dut_u (.MCLK(mclk), .RST(rst), .IFC_IN(ifc), .SPE_CMD(spe), .SPD_CMD(spd),
      .TALK_ADDR_CMD(tad), .UNTALK_CMD(utk), .LISTEN_ADDR_CMD(lsn), .UNLISTEN_CMD(1'b0),
      .BYTE_TAKEN(btk), .OQ_COUNT(oq), .ESR_BITS(esr), .ESE_BITS(ese), .OPER_SUM(oper),
      .MASK_WR(mwr), .MASK_WDATA(mwd), .CLS_CMD(cls), .STB_QUERY(qry), .SRQ_O(srq_o),
      .SRQ_OE(srq_oe), .DIO_O(dio), .DIO_OE(dio_oe), .TALK_ACT(tlk), .LISTEN_ACT(lsa),
      .POLL_ACT(pol), .SRQ_LAMP(lamp), .MASK_Q(mq), .STB_RESP(resp), .STB_RESP_VLD(vld));
   gssr_ctrl_model ctl_u (.MCLK(mclk), .DIO_O(dio), .DIO_OE(dio_oe), .SPE_CMD(spe),
      .TALK_ADDR_CMD(tad), .BYTE_TAKEN(btk), .SPD_CMD(spd), .UNTALK_CMD(utk));

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   task automatic stop_test;
      if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      cmp_count++;
      if (s !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask

   task automatic query(input logic [7:0] e);
      qry = 1'b1;
      cyc(1);
      qry = 1'b0;
      chk("query_byte", resp, e);
      chk("query_valid", {7'h0, vld}, 8'h01);
   endtask

   task automatic set_mask(input logic [7:0] m);
      mwr = 1'b1;
      mwd = m;
      cyc(1);
      mwr = 1'b0;
      cyc(3);
   endtask

   task automatic t_enable;
      oq = 8'h01;
      cyc(3);
      chk("srq_masked", {7'h0, srq_oe}, 8'h00);
      query(8'h10);
      set_mask(8'h40);
      chk("srq_bit6_mask", {7'h0, srq_oe}, 8'h00);
      set_mask(8'hb0);
      chk("srq_on", {7'h0, srq_oe}, 8'h01);
      chk("lamp_on", {7'h0, lamp}, 8'h01);
      query(8'h50);
      chk("srq_after_query", {7'h0, srq_oe}, 8'h01);
   endtask

   // Second reason arrives mid-poll and must survive to the next poll
   task automatic t_poll;
      fork
         ctl_u.poll(4, b);
         begin
            cyc(3);
            oq = 8'h00;
            oper = 1'b1;
            cyc(1);
            esr = 8'h20;
            ese = 8'h20;
         end
      join
      chk("poll_frozen", b, 8'h50);
      cyc(3);
      chk("srq_pending", {7'h0, srq_oe}, 8'h01);
      ctl_u.poll(0, b);
      chk("poll_pending", b, 8'he0);
      cyc(3);
      chk("srq_after_poll", {7'h0, srq_oe}, 8'h00);
   endtask

   task automatic t_cls;
      esr = 8'h00;
      cyc(2);
      oq = 8'h02;
      cyc(3);
      chk("srq_again", {7'h0, srq_oe}, 8'h01);
      cls = 1'b1;
      cyc(1);
      cls = 1'b0;
      cyc(2);
      chk("srq_cls", {7'h0, srq_oe}, 8'h00);
   endtask

   task automatic t_ifc;
      lsn = 1'b1;
      cyc(1);
      lsn = 1'b0;
      cyc(1);
      chk("listen", {7'h0, lsa}, 8'h01);
      ifc = 1'b1;
      cyc(1);
      ifc = 1'b0;
      chk("unaddressed", {5'h0, lsa, tlk, pol}, 8'h00);
   endtask

   initial begin
      {rst, ifc, lsn, mwr, cls, qry, oper} = 7'h40;
      {oq, esr, ese, mwd} = 32'h0000_0000;
      cyc(6);
      rst = 1'b0;
      cyc(1);
      chk("mask_reset", mq, 8'h00);
      t_enable();
      t_poll();
      t_cls();
      t_ifc();
      stop_test();
   end

   // Whole run needs about 55 cycles
   initial begin
      #20000;
      mismatches++;
      stop_test();
   end
endmodule
